// ---- design/cbs_sequencer.sv ----
/*
 * Bus cycle sequencer: drives address, data and strobes for immediate and
 * direct sequences, and the pin states of reset, standby, halt and sleep.
 * Assumes the instruction decoder issues one command at a time on i_start
 * while o_ready is high, and that i_bus_data is the read byte already
 * captured by the core in this clock domain at the end of each bus cycle.
 */
// Summary of operation
// - Next opcode fetch overlaps the end of an instruction, except prefetching ops, which fetch it first.
// - Cycle count comes from the sequence, not from fetch-to-fetch spacing.
// - Reset and sleep: strobes and fetch marker high, bus granted low.
// - Halt: read, write, direction floated; fetch marker and granted high.
// - Standby: every control, clock output, address, data and ports float.
// - Address high in reset/sleep, floats otherwise; data floats; ports keep in halt/sleep.
// - Direct 8-bit op: address byte, operand, fetch at PC+2; three cycles.
// - Direct 16-bit load: address byte, high, low byte, fetch; four cycles.
// - Direct 16-bit store: address byte, write high then low, fetch; four cycles.
// - Direct call: target, dummy FFFF, push low at SP, high at SP-1, fetch.
// - Mask test four cycles; and/or to memory six with dummy FFFF before write.
`timescale 1ns/10ps
`include "cbs_regs.svh"
module cbs_sequencer #(
	parameter int BUS_DIV   = `CBS_BUS_DIV,
	parameter int EXTRA_MAX = `CBS_EXTRA_MAX
) (
	input  wire logic           i_clock,
	input  wire logic           i_nrst,
	input  wire logic           i_halt_pin_n,
	input  wire logic           i_standby_pin_n,
	input  wire logic           i_sleep,
	input  wire logic           i_start,
	input  wire cbs_pkg::cbs_op_t i_op,
	input  wire logic [15:0]    i_pc,
	input  wire logic [15:0]    i_sp,
	input  wire logic [15:0]    i_wdata,
	input  wire logic [3:0]     i_extra,
	input  wire logic [7:0]     i_bus_data,
	output logic                o_ready,
	output logic                o_done,
	output logic [2:0]          o_cycles,
	output logic [15:0]         o_addr,
	output logic                o_addr_oe_n,
	output logic [7:0]          o_data,
	output logic                o_data_oe_n,
	output logic                o_rd_n,
	output logic                o_wr_n,
	output logic                o_rw,
	output logic                o_ctrl_oe_n,
	output logic                o_opcode_fetch_marker_n,
	output logic                o_bus_granted,
	output logic                o_status_oe_n,
	output logic                o_clock_out_oe_n,
	output logic                o_port_float,
	output logic                o_port_hold
);
	import cbs_pkg::*;

	typedef struct packed {
		cbs_mode_t   mode;
		logic        busy;
		logic        ready;
		logic        done;
		cbs_op_t     op;
		logic [2:0]  step;
		logic [3:0]  extra;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] wdata;
		logic [7:0]  opaddr;
		logic [2:0]  cycles;
		logic [15:0] addr;
		logic        addr_oe_n;
		logic [7:0]  data;
		logic        data_oe_n;
		logic        rd_n;
		logic        wr_n;
		logic        rw;
		logic        ctrl_oe_n;
		logic        marker_n;
		logic        granted;
		logic        status_oe_n;
		logic        clk_oe_n;
		logic        port_float;
		logic        port_hold;
	} cbs_seq_state_t;

	// Reset puts the pins in their reset posture straight away.
	localparam cbs_seq_state_t RESET_STATE = '{
		mode: CBS_RUN, busy: 1'b0, ready: 1'b0, done: 1'b0, op: CBS_IMM8,
		step: 3'h0, extra: 4'h0, pc: 16'h0000, sp: 16'h0000, wdata: 16'h0000,
		opaddr: 8'h00, cycles: 3'h0, addr: `CBS_ADDR_RESET, addr_oe_n: 1'b0,
		data: 8'h00, data_oe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, rw: 1'b1,
		ctrl_oe_n: 1'b0, marker_n: 1'b1, granted: 1'b0, status_oe_n: 1'b0,
		clk_oe_n: 1'b0, port_float: 1'b1, port_hold: 1'b0};

	if (EXTRA_MAX < 0 || EXTRA_MAX > 15) begin : g_bad_extra
		$error("EXTRA_MAX out of range");
	end

	cbs_seq_state_t state_reg;
	cbs_seq_state_t state_next;
	logic           tick;
	logic [1:0]     pins;

	cbs_div #(
		.DIV(BUS_DIV)
	) u_div (
		.i_clock(i_clock),
		.i_nrst (i_nrst),
		.o_tick (tick)
	);

	cbs_sync2 #(
		.W   (2),
		.INIT(2'b11)
	) u_sync (
		.i_clock(i_clock),
		.i_nrst (i_nrst),
		.i_async({i_halt_pin_n, i_standby_pin_n}),
		.o_sync (pins)
	);

	// sequence length
	// Length is fixed per sequence kind, and set by extra for prefetch, so the count never depends on fetch spacing.
	function automatic logic [2:0] seq_len(input cbs_op_t op, input logic [3:0] extra);
		case (op)
			CBS_IMM8:     seq_len = `CBS_LEN_IMM8;
			CBS_IMM16:    seq_len = `CBS_LEN_IMM16;
			CBS_DIR8:     seq_len = `CBS_LEN_DIR8;
			CBS_DIR_ST8:  seq_len = `CBS_LEN_DIR8;
			CBS_DIR16:    seq_len = `CBS_LEN_DIR16;
			CBS_DIR_ST16: seq_len = `CBS_LEN_DIR16;
			CBS_CALL:     seq_len = `CBS_LEN_CALL;
			CBS_TEST:     seq_len = `CBS_LEN_TEST;
			CBS_MODIFY:   seq_len = `CBS_LEN_MODIFY;
			CBS_PREFETCH: seq_len = (extra > 4'h6) ? 3'h7 : 3'(extra + 4'h1);
			default:      seq_len = `CBS_LEN_IMM8;
		endcase
	endfunction : seq_len

	function automatic logic [15:0] dir_addr(input logic [7:0] a);
		dir_addr = {`CBS_PAGE_ZERO, a};
	endfunction : dir_addr

	logic [15:0] cyc_addr;
	cbs_cyc_t    cyc_kind;
	logic [7:0]  cyc_wdata;
	logic        cyc_capture;
	logic [2:0]  last_step;
	logic [15:0] ret_addr;
	logic [7:0]  op_byte;

	always_comb begin
		cyc_addr = `CBS_DUMMY_ADDR;
		cyc_kind = CBS_CYC_DUMMY;
		cyc_wdata = 8'h00;
		// A byte read in one cycle is only on i_bus_data at the tick that ends it.
		cyc_capture = (state_reg.op == CBS_TEST || state_reg.op == CBS_MODIFY)
			? (state_reg.step == 3'h3) : (state_reg.step == 3'h2);
		op_byte = cyc_capture ? i_bus_data : state_reg.opaddr;
		last_step = seq_len(state_reg.op, state_reg.extra);
		ret_addr = state_reg.pc + 16'h0002;
		case (state_reg.op)
			CBS_IMM8, CBS_IMM16: begin
				cyc_addr = state_reg.pc + 16'(state_reg.step);
				cyc_kind = (state_reg.step == last_step) ? CBS_CYC_FETCH : CBS_CYC_READ;
			end
			CBS_DIR8, CBS_DIR16: begin
				cyc_kind = CBS_CYC_READ;
				if (state_reg.step == 3'h1) begin
					cyc_addr = state_reg.pc + 16'h0001;
				end else if (state_reg.step == last_step) begin
					cyc_addr = state_reg.pc + 16'h0002;
					cyc_kind = CBS_CYC_FETCH;
				end else begin
					cyc_addr = dir_addr(op_byte) + 16'(state_reg.step - 3'h2);
				end
			end
			CBS_DIR_ST8, CBS_DIR_ST16: begin
				cyc_kind = CBS_CYC_READ;
				if (state_reg.step == 3'h1) begin
					cyc_addr = state_reg.pc + 16'h0001;
				end else if (state_reg.step == last_step) begin
					cyc_addr = state_reg.pc + 16'h0002;
					cyc_kind = CBS_CYC_FETCH;
				end else begin
					cyc_addr = dir_addr(op_byte) + 16'(state_reg.step - 3'h2);
					cyc_kind = CBS_CYC_WRITE;
					if (state_reg.op == CBS_DIR_ST8 || state_reg.step == 3'h3) begin
						cyc_wdata = state_reg.wdata[7:0];
					end else begin
						cyc_wdata = state_reg.wdata[15:8];
					end
				end
			end
			CBS_CALL: begin
				case (state_reg.step)
					3'h1: begin
						cyc_addr = state_reg.pc + 16'h0001;
						cyc_kind = CBS_CYC_READ;
					end
					3'h2: cyc_kind = CBS_CYC_DUMMY;
					3'h3: begin
						cyc_addr = state_reg.sp;
						cyc_kind = CBS_CYC_WRITE;
						cyc_wdata = ret_addr[7:0];
					end
					3'h4: begin
						cyc_addr = state_reg.sp - 16'h0001;
						cyc_kind = CBS_CYC_WRITE;
						cyc_wdata = ret_addr[15:8];
					end
					default: begin
						cyc_addr = dir_addr(state_reg.opaddr);
						cyc_kind = CBS_CYC_FETCH;
					end
				endcase
			end
			CBS_TEST, CBS_MODIFY: begin
				cyc_kind = CBS_CYC_READ;
				if (state_reg.step == last_step) begin
					cyc_addr = state_reg.pc + 16'h0003;
					cyc_kind = CBS_CYC_FETCH;
				end else if (state_reg.step < 3'h3) begin
					cyc_addr = state_reg.pc + 16'(state_reg.step);
				end else if (state_reg.step == 3'h4) begin
					cyc_kind = CBS_CYC_DUMMY;
				end else begin
					cyc_addr = dir_addr(op_byte);
					cyc_kind = (state_reg.step == 3'h5) ? CBS_CYC_WRITE : CBS_CYC_READ;
					cyc_wdata = state_reg.wdata[7:0];
				end
			end
			// prefetch then execute
			// The opcode after a prefetching op is fetched first; internal cycles follow.
			CBS_PREFETCH: begin
				if (state_reg.step == 3'h1) begin
					cyc_addr = state_reg.pc + 16'h0001;
					cyc_kind = CBS_CYC_FETCH;
				end
			end
			default: cyc_kind = CBS_CYC_DUMMY;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (!pins[0]) begin
			state_next.mode = CBS_STANDBY;
			state_next.busy = 1'b0;
		end else if (state_reg.mode == CBS_STANDBY) begin
			// Leaving standby restarts like a reset, so the bus posture is rebuilt.
			state_next = RESET_STATE;
		end else if (tick) begin
			if (state_reg.busy) begin
				state_next.addr = cyc_addr;
				state_next.data = cyc_wdata;
				state_next.data_oe_n = (cyc_kind != CBS_CYC_WRITE);
				state_next.rw = (cyc_kind != CBS_CYC_WRITE);
				state_next.wr_n = (cyc_kind != CBS_CYC_WRITE);
				state_next.rd_n = (cyc_kind == CBS_CYC_WRITE) || (cyc_kind == CBS_CYC_DUMMY);
				state_next.marker_n = (cyc_kind != CBS_CYC_FETCH);
				state_next.step = state_reg.step + 3'h1;
				if (cyc_capture) begin
					state_next.opaddr = i_bus_data;
				end
				if (state_reg.step == last_step) begin
					state_next.busy = 1'b0;
					state_next.done = 1'b1;
					state_next.cycles = last_step;
				end
			end else begin
				state_next.addr = `CBS_ADDR_RESET;
				state_next.data_oe_n = 1'b1;
				state_next.rd_n = 1'b1;
				state_next.wr_n = 1'b1;
				state_next.rw = 1'b1;
				state_next.marker_n = 1'b1;
				if (!pins[1]) begin
					state_next.mode = CBS_HALT;
				end else if (i_sleep) begin
					state_next.mode = CBS_SLEEP;
				end else begin
					state_next.mode = CBS_RUN;
				end
			end
		end
		if (state_reg.ready && i_start) begin
			state_next.busy = 1'b1;
			state_next.op = i_op;
			state_next.step = 3'h1;
			state_next.extra = (i_extra > 4'(EXTRA_MAX)) ? 4'(EXTRA_MAX) : i_extra;
			state_next.pc = i_pc;
			state_next.sp = i_sp;
			state_next.wdata = i_wdata;
			state_next.mode = CBS_RUN;
		end
		state_next.ready = !state_next.busy && state_next.mode == CBS_RUN && pins == 2'b11
			&& !i_sleep && !(state_reg.ready && i_start);
		state_next.clk_oe_n = (state_next.mode == CBS_STANDBY);
		case (state_next.mode)
			CBS_STANDBY: begin
				state_next.addr_oe_n = 1'b1;
				state_next.data_oe_n = 1'b1;
				state_next.ctrl_oe_n = 1'b1;
				state_next.status_oe_n = 1'b1;
				state_next.port_float = 1'b1;
				state_next.port_hold = 1'b0;
			end
			CBS_HALT: begin
				state_next.addr_oe_n = 1'b1;
				state_next.data_oe_n = 1'b1;
				state_next.ctrl_oe_n = 1'b1;
				state_next.status_oe_n = 1'b0;
				state_next.marker_n = 1'b1;
				state_next.granted = 1'b1;
				state_next.port_float = 1'b0;
				state_next.port_hold = 1'b1;
			end
			CBS_SLEEP: begin
				state_next.addr_oe_n = 1'b0;
				state_next.ctrl_oe_n = 1'b0;
				state_next.status_oe_n = 1'b0;
				state_next.granted = 1'b0;
				state_next.port_float = 1'b0;
				state_next.port_hold = 1'b1;
			end
			default: begin
				state_next.addr_oe_n = 1'b0;
				state_next.ctrl_oe_n = 1'b0;
				state_next.status_oe_n = 1'b0;
				state_next.granted = 1'b0;
				state_next.port_float = 1'b0;
				state_next.port_hold = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= RESET_STATE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_ready = state_reg.ready;
	assign o_done = state_reg.done;
	assign o_cycles = state_reg.cycles;
	assign o_addr = state_reg.addr;
	assign o_addr_oe_n = state_reg.addr_oe_n;
	assign o_data = state_reg.data;
	assign o_data_oe_n = state_reg.data_oe_n;
	assign o_rd_n = state_reg.rd_n;
	assign o_wr_n = state_reg.wr_n;
	assign o_rw = state_reg.rw;
	assign o_ctrl_oe_n = state_reg.ctrl_oe_n;
	assign o_opcode_fetch_marker_n = state_reg.marker_n;
	assign o_bus_granted = state_reg.granted;
	assign o_status_oe_n = state_reg.status_oe_n;
	assign o_clock_out_oe_n = state_reg.clk_oe_n;
	assign o_port_float = state_reg.port_float;
	assign o_port_hold = state_reg.port_hold;
endmodule : cbs_sequencer

// ---- inc/cbs_regs.svh ----
/*
 * Constants of the bus cycle sequencer: addresses, reset values and pacing.
 * Assumes it is included by bare name from the sequencer design file; the package does not include it.
 */
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

`define CBS_DUMMY_ADDR   16'hffff
`define CBS_ADDR_RESET   16'hffff
`define CBS_PAGE_ZERO    8'h00
`define CBS_BUS_DIV      4
`define CBS_EXTRA_MAX    15
`define CBS_LEN_IMM8     3'h2
`define CBS_LEN_IMM16    3'h3
`define CBS_LEN_DIR8     3'h3
`define CBS_LEN_DIR16    3'h4
`define CBS_LEN_CALL     3'h5
`define CBS_LEN_TEST     3'h4
`define CBS_LEN_MODIFY   3'h6

`endif

// ---- inc/cbs_pkg.sv ----
/*
 * Types of the bus cycle sequencer: sequence kinds, pin modes, bus cycle kinds.
 * Assumes the constants header is on the include path.
 */
package cbs_pkg;
	typedef enum logic [3:0] {
		CBS_IMM8     = 4'h0,
		CBS_IMM16    = 4'h1,
		CBS_DIR8     = 4'h2,
		CBS_DIR_ST8  = 4'h3,
		CBS_DIR16    = 4'h4,
		CBS_DIR_ST16 = 4'h5,
		CBS_CALL     = 4'h6,
		CBS_TEST     = 4'h7,
		CBS_MODIFY   = 4'h8,
		CBS_PREFETCH = 4'h9
	} cbs_op_t;

	typedef enum logic [1:0] {
		CBS_RUN     = 2'h0,
		CBS_HALT    = 2'h1,
		CBS_SLEEP   = 2'h2,
		CBS_STANDBY = 2'h3
	} cbs_mode_t;

	typedef enum logic [1:0] {
		CBS_CYC_READ  = 2'h0,
		CBS_CYC_WRITE = 2'h1,
		CBS_CYC_FETCH = 2'h2,
		CBS_CYC_DUMMY = 2'h3
	} cbs_cyc_t;
endpackage : cbs_pkg

// ---- design/cbs_sync2.sv ----
/*
 * Two flip-flop synchroniser for pin levels.
 * Assumes the inputs are asynchronous levels; the first stage feeds only the second.
 */
`timescale 1ns/10ps
module cbs_sync2 #(
	parameter int         W     = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input  wire logic         i_clock,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} cbs_sync_state_t;

	cbs_sync_state_t state_reg;
	cbs_sync_state_t state_next;

	always_comb begin
		state_next.s1 = i_async;
		state_next.s2 = state_reg.s1;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= {INIT, INIT};
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_sync = state_reg.s2;
endmodule : cbs_sync2

// ---- design/cbs_div.sv ----
/*
 * Divider that paces bus cycles with a one-cycle enable pulse.
 * Assumes a single clock; DIV is the number of clocks per bus cycle.
 */
`timescale 1ns/10ps
module cbs_div #(
	parameter int DIV = 4
) (
	input  wire logic i_clock,
	input  wire logic i_nrst,
	output logic      o_tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} cbs_div_state_t;

	cbs_div_state_t state_reg;
	cbs_div_state_t state_next;

	if (DIV < 1 || DIV > 256) begin : g_bad_div
		$error("DIV out of range");
	end

	always_comb begin
		state_next = state_reg;
		state_next.tick = (state_reg.cnt == 8'(DIV - 1));
		state_next.cnt = state_next.tick ? 8'h00 : state_reg.cnt + 8'h01;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_tick = state_reg.tick;
endmodule : cbs_div

// ---- bench/cbs_mem_model.sv ----
/*
 * Memory and peripherals on the far side of the system bus.
 * Assumes the sequencer samples the byte at the clock edge ending a read cycle.
 */
`timescale 1ns/10ps
module cbs_mem_model (
	input  wire logic        i_clock,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_rd_n,
	input  wire logic [7:0]  i_salt,
	output logic      [7:0]  o_byte
);
	logic [7:0] last_reg = 8'h00;

	// Released lines show the inverse of the last byte, so stale data never passes.
	assign o_byte = i_rd_n ? ~last_reg : (i_addr[7:0] ^ i_addr[15:8] ^ i_salt);

	always_ff @(posedge i_clock) begin
		if (!i_rd_n) begin
			last_reg <= o_byte;
		end
	end
endmodule : cbs_mem_model

// ---- bench/cbs_sequencer_checker.sv ----
/*
 * Concurrent checks on the pins of the bus cycle sequencer.
 * Assumes it is bound to cbs_sequencer; length checks apply when BUS_DIV is 1.
 */
`timescale 1ns/10ps
module cbs_sequencer_checker #(
	parameter int BUS_DIV = 4
) (
	input wire logic             i_clock,
	input wire logic             i_nrst,
	input wire logic             i_standby_pin_n,
	input wire logic             i_start,
	input wire cbs_pkg::cbs_op_t i_op,
	input wire logic             o_ready,
	input wire logic             o_done,
	input wire logic [15:0]      o_addr,
	input wire logic             o_addr_oe_n,
	input wire logic             o_data_oe_n,
	input wire logic             o_rd_n,
	input wire logic             o_wr_n,
	input wire logic             o_rw,
	input wire logic             o_ctrl_oe_n,
	input wire logic             o_opcode_fetch_marker_n,
	input wire logic             o_bus_granted,
	input wire logic             o_status_oe_n,
	input wire logic             o_clock_out_oe_n,
	input wire logic             o_port_float,
	input wire logic             o_port_hold
);
	import cbs_pkg::*;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	sequence seq_take(cbs_op_t op);
		o_ready && i_start && i_op == op;
	endsequence
	sequence seq_standby;
		!i_standby_pin_n [*5];
	endsequence

	chk_fetch_read: assert property (
		!o_opcode_fetch_marker_n && !o_status_oe_n |-> !o_rd_n && o_wr_n && o_rw && !o_ctrl_oe_n)
		else $error("fetch cycle is not a read");
	chk_write_cycle: assert property (
		!o_wr_n && !o_ctrl_oe_n |-> !o_rw && o_rd_n && !o_data_oe_n && o_opcode_fetch_marker_n)
		else $error("write cycle strobes wrong");
	chk_dummy_addr: assert property (
		!o_ready && !$past(o_ready) && o_rd_n && o_wr_n && !o_ctrl_oe_n |-> o_addr == 16'hffff)
		else $error("idle cycle not at ffff");
	chk_halt_pins: assert property (
		o_bus_granted |-> o_ctrl_oe_n && o_addr_oe_n && o_opcode_fetch_marker_n && o_port_hold)
		else $error("halt posture wrong");
	chk_sleep_pins: assert property (
		o_port_hold && !o_bus_granted |-> o_addr == 16'hffff && !o_addr_oe_n && o_rd_n && o_wr_n)
		else $error("sleep posture wrong");
	chk_standby_float: assert property (
		seq_standby |-> o_ctrl_oe_n && o_addr_oe_n && o_data_oe_n && o_clock_out_oe_n
			&& o_port_float)
		else $error("standby posture wrong");
	chk_done_ready: assert property (o_done |=> o_ready && !o_done)
		else $error("ready not back after done");

	// Cycle lengths are only fixed in clocks when every clock is a bus cycle.
	if (BUS_DIV == 1) begin : g_len
		chk_imm8_len: assert property (seq_take(CBS_IMM8) |=> !o_done [*2] ##1 o_done)
			else $error("short operation length wrong");
		chk_call_len: assert property (seq_take(CBS_CALL) |=> !o_done [*5] ##1 o_done)
			else $error("call length wrong");
		chk_modify_len: assert property (seq_take(CBS_MODIFY) |=> !o_done [*6] ##1 o_done)
			else $error("modify length wrong");
	end
endmodule : cbs_sequencer_checker

bind cbs_sequencer cbs_sequencer_checker #(.BUS_DIV(BUS_DIV)) cbs_sequencer_checker_i (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_standby_pin_n(i_standby_pin_n),
	.i_start(i_start), .i_op(i_op), .o_ready(o_ready), .o_done(o_done), .o_addr(o_addr),
	.o_addr_oe_n(o_addr_oe_n), .o_data_oe_n(o_data_oe_n), .o_rd_n(o_rd_n),
	.o_wr_n(o_wr_n), .o_rw(o_rw), .o_ctrl_oe_n(o_ctrl_oe_n),
	.o_opcode_fetch_marker_n(o_opcode_fetch_marker_n), .o_bus_granted(o_bus_granted),
	.o_status_oe_n(o_status_oe_n), .o_clock_out_oe_n(o_clock_out_oe_n),
	.o_port_float(o_port_float), .o_port_hold(o_port_hold));

// ---- bench/tb_cpu_bus_cycle_sequencer.sv ----
/*
 * Self-checking bench: a queue model of every bus cycle against the sequencer.
 * Assumes BUS_DIV of 1, so each clock after the taking edge is one bus cycle.
 */
`timescale 1ns/10ps
module tb_cpu_bus_cycle_sequencer;
	import cbs_pkg::*;
	logic        i_clock = 1'b0;
	logic        i_nrst = 1'b0;
	logic        i_halt_pin_n = 1'b1;
	logic        i_standby_pin_n = 1'b1;
	logic        i_sleep = 1'b0;
	logic        i_start = 1'b0;
	cbs_op_t     i_op = CBS_IMM8;
	logic [15:0] i_pc = 16'h0000;
	logic [15:0] i_sp = 16'h0000;
	logic [15:0] i_wdata = 16'h0000;
	logic [3:0]  i_extra = 4'h0;
	logic [7:0]  i_bus_data;
	logic [7:0]  salt = 8'h00;
	logic        o_ready, o_done, o_addr_oe_n, o_data_oe_n, o_rd_n, o_wr_n, o_rw;
	logic        o_ctrl_oe_n, o_opcode_fetch_marker_n, o_bus_granted, o_status_oe_n;
	logic        o_clock_out_oe_n, o_port_float, o_port_hold;
	logic [2:0]  o_cycles;
	logic [15:0] o_addr;
	logic [7:0]  o_data;
	logic [3:0]  ctl [4] = '{4'h7, 4'h9, 4'h6, 4'hf};
	int          n_errors = 0;
	int          num_checks = 0;
	int          seed = 77;
	int          cyc = 0;
	int          ea[$], ek[$], ed[$];

	always #5 i_clock = ~i_clock;

	cbs_sequencer #(.BUS_DIV(1)) cbs_sequencer_i (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_halt_pin_n(i_halt_pin_n),
		.i_standby_pin_n(i_standby_pin_n), .i_sleep(i_sleep), .i_start(i_start),
		.i_op(i_op), .i_pc(i_pc), .i_sp(i_sp), .i_wdata(i_wdata), .i_extra(i_extra),
		.i_bus_data(i_bus_data), .o_ready(o_ready), .o_done(o_done), .o_cycles(o_cycles),
		.o_addr(o_addr), .o_addr_oe_n(o_addr_oe_n), .o_data(o_data),
		.o_data_oe_n(o_data_oe_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_rw(o_rw),
		.o_ctrl_oe_n(o_ctrl_oe_n), .o_opcode_fetch_marker_n(o_opcode_fetch_marker_n),
		.o_bus_granted(o_bus_granted), .o_status_oe_n(o_status_oe_n),
		.o_clock_out_oe_n(o_clock_out_oe_n), .o_port_float(o_port_float),
		.o_port_hold(o_port_hold));
	cbs_mem_model cbs_mem_model_i (.i_clock(i_clock), .i_addr(o_addr), .i_rd_n(o_rd_n),
		.i_salt(salt), .o_byte(i_bus_data));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task finish_test;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	function int mb(input int a);
		return (a ^ (a >> 8) ^ salt) & 255;
	endfunction : mb

	task cy(input int a, input int k, input int d);
		ea.push_back(a & 16'hffff);
		ek.push_back(k);
		ed.push_back(d & 255);
	endtask : cy

	task automatic wait_hi(ref logic s);
		for (int n = 0; n < 20 && s !== 1'b1; n++) @(posedge i_clock) #1;
	endtask : wait_hi

	// Kinds: 0 read, 1 write, 2 opcode fetch, 3 dummy.
	task run(input cbs_op_t op);
		int p, s, w, x, b1, b2, n;
		p = $random(seed);
		s = $random(seed);
		w = $random(seed);
		x = $unsigned($random(seed)) % 7;
		ea.delete();
		ek.delete();
		ed.delete();
		wait_hi(o_ready);
		@(posedge i_clock);
		i_op <= op;
		i_pc <= p[15:0];
		i_sp <= s[15:0];
		i_wdata <= w[15:0];
		i_extra <= x[3:0];
		salt <= w[23:16];
		i_start <= 1'b1;
		#1;
		p = p & 16'hffff;
		b1 = mb(p + 1);
		b2 = mb(p + 2);
		cy(p + 1, op == CBS_PREFETCH ? 2 : 0, 0);
		case (op)
			CBS_IMM8: cy(p + 2, 2, 0);
			CBS_IMM16: begin cy(p + 2, 0, 0); cy(p + 3, 2, 0); end
			CBS_DIR8: begin cy(b1, 0, 0); cy(p + 2, 2, 0); end
			CBS_DIR_ST8: begin cy(b1, 1, w); cy(p + 2, 2, 0); end
			CBS_DIR16: begin cy(b1, 0, 0); cy(b1 + 1, 0, 0); cy(p + 2, 2, 0); end
			CBS_DIR_ST16: begin cy(b1, 1, w >> 8); cy(b1 + 1, 1, w); cy(p + 2, 2, 0); end
			CBS_CALL: begin
				cy(16'hffff, 3, 0);
				cy(s, 1, p + 2);
				cy(s - 1, 1, (p + 2) >> 8);
				cy(b1, 2, 0);
			end
			CBS_TEST: begin cy(p + 2, 0, 0); cy(b2, 0, 0); cy(p + 3, 2, 0); end
			CBS_MODIFY: begin
				cy(p + 2, 0, 0);
				cy(b2, 0, 0);
				cy(16'hffff, 3, 0);
				cy(b2, 1, w);
				cy(p + 3, 2, 0);
			end
			default: repeat (x) cy(16'hffff, 3, 0);
		endcase
		n = ea.size();
		@(posedge i_clock) i_start <= 1'b0;
		// A start while busy must leave no trace on the bus.
		// A one-cycle sequence is ready again by then, so it gets no stray start.
		for (int k = 0; k < n; k++) begin
			@(posedge i_clock) i_start <= (k == 0 && n > 1);
			#1;
			check(o_addr, ea[k]);
			check({o_rd_n, o_wr_n, o_rw, o_opcode_fetch_marker_n}, ctl[ek[k]]);
			if (ek[k] == 1) check(o_data, ed[k]);
			check(o_done, k == n - 1);
		end
		@(posedge i_clock) #1;
		check({o_ready, o_cycles}, 8 + n);
	endtask : run

	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		repeat (10) @(posedge i_clock);
		check({o_addr, o_rd_n, o_wr_n, o_rw, o_opcode_fetch_marker_n, o_bus_granted}, 21'h1ffffe);
		check({o_addr_oe_n, o_data_oe_n, o_ctrl_oe_n, o_port_float}, 4'h5);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clock);
		for (int i = 0; i < 40; i++) run(cbs_op_t'(i < 10 ? i : $unsigned($random(seed)) % 10));
		@(posedge i_clock) i_halt_pin_n <= 1'b0;
		wait_hi(o_bus_granted);
		@(posedge i_clock) i_start <= 1'b1;
		@(posedge i_clock) i_start <= 1'b0;
		#1;
		check({o_ctrl_oe_n, o_addr_oe_n, o_data_oe_n, o_opcode_fetch_marker_n, o_port_hold,
			o_status_oe_n, o_bus_granted}, 7'h7d);
		i_halt_pin_n <= 1'b1;
		run(CBS_DIR8);
		@(posedge i_clock) i_sleep <= 1'b1;
		wait_hi(o_port_hold);
		check({o_addr, o_addr_oe_n, o_rd_n, o_wr_n, o_rw, o_opcode_fetch_marker_n, o_bus_granted,
			o_data_oe_n, o_port_float}, 24'hffff7a);
		@(posedge i_clock) i_sleep <= 1'b0;
		run(CBS_CALL);
		@(posedge i_clock) i_standby_pin_n <= 1'b0;
		wait_hi(o_clock_out_oe_n);
		check({o_addr_oe_n, o_data_oe_n, o_ctrl_oe_n, o_status_oe_n, o_port_float, o_port_hold},
			6'h3e);
		@(posedge i_clock) i_standby_pin_n <= 1'b1;
		run(CBS_MODIFY);
		run(CBS_PREFETCH);
		finish_test();
	end
endmodule : tb_cpu_bus_cycle_sequencer
